// ===== hw/amr_pkg.sv
package amr_pkg;
  // command codes
  localparam logic [7:0] CMD_READ_MULT     = 8'hc4;
  localparam logic [7:0] CMD_READ_MULT_EXT = 8'h29;
  localparam logic [7:0] CMD_NATIVE_MAX    = 8'hf8;
  // task-file register indexes on the host port
  localparam logic [2:0] TF_DATA   = 3'h0;
  localparam logic [2:0] TF_ERR    = 3'h1;
  localparam logic [2:0] TF_COUNT  = 3'h2;
  localparam logic [2:0] TF_SECNUM = 3'h3;
  localparam logic [2:0] TF_CYLLO  = 3'h4;
  localparam logic [2:0] TF_CYLHI  = 3'h5;
  localparam logic [2:0] TF_DEVHD  = 3'h6;
  localparam logic [2:0] TF_CMD    = 3'h7;
  // field positions
  localparam int DEVHD_LBA_BIT = 6;
  localparam int ST_BSY        = 7;
  localparam int ST_RDY        = 6;
  localparam int ST_DSC        = 4;
  localparam int ST_DRQ        = 3;
  localparam int ST_ERR        = 0;
  localparam int ER_UNC        = 6;
  localparam int ER_ABT        = 2;
  // reset values and limits
  localparam logic [7:0]  STATUS_IDLE = 8'h50;
  localparam logic [27:0] LBA28_MAX   = 28'hfffffff;
  localparam logic [16:0] EXT_ZERO_CNT = 17'h10000;
  localparam logic [8:0]  STD_ZERO_CNT = 9'h100;
  localparam int SECTOR_WORDS = 256;
  // command interpreter states
  typedef enum logic [2:0] {
    AMR_IDLE  = 3'b000,
    AMR_FETCH = 3'b001,
    AMR_XFER  = 3'b010,
    AMR_WAIT  = 3'b011,
    AMR_DONE  = 3'b100
  } amr_state_e;
endpackage : amr_pkg

// ===== hw/amr_stream_if.sv
`timescale 1ns/1ps
interface amr_stream_if #(parameter int W = 16);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : amr_stream_if

// ===== hw/amr_skid_buf.sv
`timescale 1ns/1ps
// two-entry buffer: a stall by the host loses no word
module amr_skid_buf #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // streams
  amr_stream_if.snk in_s,
  amr_stream_if.src out_s
);
  initial if (W < 1) $error("width must be positive");
  logic [W-1:0] mem [2];
  logic         wp;
  logic         rp;
  logic [1:0]   cnt;
  wire          push = in_s.valid && in_s.ready;
  wire          pop  = out_s.valid && out_s.ready;
  // flags are honest full and empty
  assign in_s.ready  = (cnt != 2'd2);
  assign out_s.valid = (cnt != 2'd0);
  assign out_s.data  = mem[rp];
  // pointer and count update
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wp  <= 1'b0;
      rp  <= 1'b0;
      cnt <= 2'd0;
    end
    else
    begin
      if (push) wp <= ~wp;
      if (pop) rp <= ~rp;
      cnt <= cnt + {1'b0, push} - {1'b0, pop};
    end
  end
  // storage
  always_ff @(posedge clk)
  begin
    if (push) mem[wp] <= in_s.data;
  end
  property p_no_overflow;
    @(posedge clk) disable iff (rst) (cnt == 2'd2) |-> !push;
  endproperty
  a_no_overflow: assert property (p_no_overflow) else $error("buffer overflow");
endmodule : amr_skid_buf

// ===== hw/amr_blk_count.sv
`timescale 1ns/1ps
// counts words within a sector and sectors within a block
module amr_blk_count #(
  parameter int SW = 256
) (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // control
  input wire logic       clear,
  input wire logic       word,
  input wire logic [7:0] blk_size,
  // flags
  output logic           sector_end,
  output logic           block_end
);
  initial if (SW < 2 || SW > 65536) $error("sector word count out of range");
  logic [15:0] wcnt;
  logic [7:0]  scnt;
  assign sector_end = word && (wcnt == 16'(SW - 1));
  // a block size of zero means the whole command is one block: only the last sector interrupts
  assign block_end  = sector_end && (blk_size != 8'd0) && ((scnt + 8'd1) == blk_size);
  always_ff @(posedge clk)
  begin
    if (rst || clear)
    begin
      wcnt <= 16'd0;
      scnt <= 8'd0;
    end
    else if (word)
    begin
      wcnt <= sector_end ? 16'd0 : wcnt + 16'd1;
      if (sector_end) scnt <= block_end ? 8'd0 : scnt + 8'd1;
    end
  end
endmodule : amr_blk_count

// ===== hw/amr_top.sv
`timescale 1ns/1ps
// Contract
// - C4h reads sectors then sends them
// - data moves as 16-bit words
// - one interrupt per block, not sector
// - 29h does extended 48-bit block read
// - extended count: current low, previous high
// - extended count zero means 65,536 sectors
// - 48-bit address from current and previous bytes
// - error address reported, high bytes via select
// - F8h returns native max, ignoring limits
// - clamp to 268,435,455 above 28 bits
// - logical mode: bits 0-7 in sector number
// - logical mode: 8-15 cyl low, 16-23 high
// - geometry mode: max cylinder and sector
// - head field: bits 24-27 or max head
module amr_top
  import amr_pkg::*;
#(
  parameter int          SW         = SECTOR_WORDS,
  parameter logic [47:0] NATIVE_MAX = 48'h0000_0fff_ffff,
  parameter logic [15:0] MAX_CYL    = 16'h3fff,
  parameter logic [3:0]  MAX_HEAD   = 4'hf,
  parameter logic [7:0]  MAX_SECT   = 8'h3f
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // host task-file port
  input wire logic        tf_wr,
  input wire logic        tf_rd,
  input wire logic [2:0]  tf_addr,
  input wire logic [7:0]  tf_wdata,
  input wire logic        tf_hob,
  output logic [7:0]      tf_rdata,
  // data register stream to host
  output logic            data_valid,
  input wire logic        data_ready,
  output logic [15:0]     data_word,
  // host interrupt
  output logic            intrq,
  // block size from set-multiple setup
  input wire logic [7:0]  blk_size,
  // media side
  output logic            media_req,
  output logic [47:0]     media_lba,
  input wire logic        media_valid,
  input wire logic [15:0] media_data,
  input wire logic        media_unc,
  output logic            media_ready
);
  initial if (SW < 2) $error("sector size too small");

  amr_state_e  state;
  amr_state_e  next_state;
  // task file: current and previous bytes
  logic [7:0]  cnt_cur, cnt_prv, sn_cur, sn_prv, cl_cur, cl_prv, ch_cur, ch_prv, devhd;
  logic [7:0]  status, error;
  logic [7:0]  cmd;
  logic [47:0] lba;
  logic [16:0] remain;
  logic        ext;
  logic        intrq_r;

  amr_stream_if #(.W(16)) fill_s ();
  amr_stream_if #(.W(16)) host_s ();

  // decode of the command write
  wire cmd_wr    = tf_wr && tf_addr == TF_CMD && !status[ST_BSY];
  wire is_rm     = tf_wdata == CMD_READ_MULT;
  wire is_rme    = tf_wdata == CMD_READ_MULT_EXT;
  wire is_nmax   = tf_wdata == CMD_NATIVE_MAX;
  wire lba_mode  = devhd[DEVHD_LBA_BIT];
  // start address and sector count for each form
  wire [47:0] lba48 = {ch_prv, cl_prv, sn_prv, ch_cur, cl_cur, sn_cur};
  wire [47:0] lba28 = {20'h0, devhd[3:0], ch_cur, cl_cur, sn_cur};
  wire [15:0] cnt16 = {cnt_prv, cnt_cur};
  wire [16:0] cnt_ext = (cnt16 == 16'h0) ? EXT_ZERO_CNT : {1'b0, cnt16};
  wire [16:0] cnt_std = (cnt_cur == 8'h0) ? {8'h0, STD_ZERO_CNT} : {9'h0, cnt_cur};
  // native max, independent of any host limit, clamped for 28 bits
  wire [27:0] nmax28 = (NATIVE_MAX > {20'h0, LBA28_MAX}) ? LBA28_MAX : NATIVE_MAX[27:0];

  // word and block tracking
  logic sector_end, block_end;
  wire  word_in = fill_s.valid && fill_s.ready;
  amr_blk_count #(.SW(SW)) u_cnt (
    .clk        (clk),
    .rst        (rst),
    .clear      (cmd_wr),
    .word       (word_in),
    .blk_size   (blk_size),
    .sector_end (sector_end),
    .block_end  (block_end)
  );

  amr_skid_buf #(.W(16)) u_buf (
    .clk   (clk),
    .rst   (rst),
    .in_s  (fill_s),
    .out_s (host_s)
  );

  // media into buffer, buffer to host; 16-bit words throughout
  wire xfer = state == AMR_XFER;
  assign fill_s.valid = xfer && media_valid && !media_unc;
  assign fill_s.data  = media_data;
  assign media_ready  = xfer && fill_s.ready;
  assign data_valid   = host_s.valid;
  assign data_word    = host_s.data;
  assign host_s.ready = data_ready;
  assign media_req    = xfer;
  assign media_lba    = lba;
  assign intrq        = intrq_r;
  wire last_sector    = remain == 17'd1;
  wire unc_hit        = xfer && media_unc;
  wire cmd_is_read    = cmd == CMD_READ_MULT || cmd == CMD_READ_MULT_EXT;

  // next state
  always_comb
  begin
    next_state = state;
    case (state)
      AMR_IDLE:  if (cmd_wr && (is_rm || is_rme)) next_state = AMR_XFER;
                 else if (cmd_wr) next_state = AMR_DONE;
      AMR_XFER:  if (unc_hit) next_state = AMR_DONE;
                 else if (sector_end && last_sector) next_state = AMR_WAIT;
      AMR_WAIT:  if (!host_s.valid) next_state = AMR_DONE;
      AMR_DONE:  next_state = AMR_IDLE;
      default:   next_state = AMR_IDLE;
    endcase
  end

  // task file writes
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      {cnt_cur, cnt_prv, sn_cur, sn_prv, cl_cur, cl_prv, ch_cur, ch_prv} <= 64'h0;
      devhd <= 8'h0;
    end
    else if (tf_wr && !status[ST_BSY] && tf_addr != TF_CMD)
    begin
      case (tf_addr)
        TF_COUNT:  begin cnt_prv <= cnt_cur; cnt_cur <= tf_wdata; end
        TF_SECNUM: begin sn_prv <= sn_cur; sn_cur <= tf_wdata; end
        TF_CYLLO:  begin cl_prv <= cl_cur; cl_cur <= tf_wdata; end
        TF_CYLHI:  begin ch_prv <= ch_cur; ch_cur <= tf_wdata; end
        TF_DEVHD:  devhd <= tf_wdata;
        default:   ;
      endcase
    end
    else if (cmd_wr && is_nmax)
    begin
      if (lba_mode)
      begin
        sn_cur <= nmax28[7:0];
        cl_cur <= nmax28[15:8];
        ch_cur <= nmax28[23:16];
        devhd  <= {devhd[7:4], nmax28[27:24]};
      end
      else
      begin
        sn_cur <= MAX_SECT;
        {ch_cur, cl_cur} <= MAX_CYL;
        devhd  <= {devhd[7:4], MAX_HEAD};
      end
    end
    else if (unc_hit && ext)
    begin
      {ch_prv, cl_prv, sn_prv, ch_cur, cl_cur, sn_cur} <= lba;
    end
    else if (unc_hit)
    begin
      {devhd[3:0], ch_cur, cl_cur, sn_cur} <= lba[27:0];
    end
  end

  // command progress, status and interrupt
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state   <= AMR_IDLE;
      status  <= STATUS_IDLE;
      error   <= 8'h0;
      cmd     <= 8'h0;
      lba     <= 48'h0;
      remain  <= 17'h0;
      ext     <= 1'b0;
      intrq_r <= 1'b0;
    end
    else
    begin
      state <= next_state;
      if (tf_rd && tf_addr == TF_CMD) intrq_r <= 1'b0;
      if (cmd_wr)
      begin
        cmd     <= tf_wdata;
        ext     <= is_rme;
        lba     <= is_rme ? lba48 : lba28;
        remain  <= is_rme ? cnt_ext : cnt_std;
        error   <= 8'h0;
        intrq_r <= 1'b0;
        status  <= (STATUS_IDLE | (8'h1 << ST_BSY)) & ~(8'h1 << ST_ERR);
        if (!(is_rm || is_rme || is_nmax)) error[ER_ABT] <= 1'b1;
      end
      if (xfer && sector_end && !unc_hit)
      begin
        remain <= remain - 17'd1;
        lba    <= lba + 48'd1;
      end
      if (xfer && (block_end || (sector_end && last_sector)))
        intrq_r <= 1'b1;
      if (unc_hit) error[ER_UNC] <= 1'b1;
      // busy drops after the done cycle, so every command shows busy for at least one cycle
      if (state == AMR_DONE)
      begin
        status[ST_BSY] <= 1'b0;
        status[ST_ERR] <= |error;
        if (error[ER_UNC] || !cmd_is_read) intrq_r <= 1'b1;
      end
      status[ST_DRQ] <= host_s.valid;
    end
  end

  // register read mux; hob selects high-order bytes
  always_ff @(posedge clk)
  begin
    if (rst) tf_rdata <= 8'h0;
    else
    begin
      case (tf_addr)
        TF_ERR:    tf_rdata <= error;
        TF_COUNT:  tf_rdata <= tf_hob ? cnt_prv : cnt_cur;
        TF_SECNUM: tf_rdata <= tf_hob ? sn_prv : sn_cur;
        TF_CYLLO:  tf_rdata <= tf_hob ? cl_prv : cl_cur;
        TF_CYLHI:  tf_rdata <= tf_hob ? ch_prv : ch_cur;
        TF_DEVHD:  tf_rdata <= devhd;
        TF_CMD:    tf_rdata <= status;
        default:   tf_rdata <= 8'h0;
      endcase
    end
  end

  property p_busy_on_cmd;
    @(posedge clk) disable iff (rst) cmd_wr |=> status[ST_BSY];
  endproperty
  a_busy_on_cmd: assert property (p_busy_on_cmd) else $error("busy not set");
  property p_ext_count;
    @(posedge clk) disable iff (rst) (cmd_wr && is_rme && cnt16 == 16'h0) |=> remain == EXT_ZERO_CNT;
  endproperty
  a_ext_count: assert property (p_ext_count) else $error("zero count not 65536");
  property p_ext_lba;
    @(posedge clk) disable iff (rst) (cmd_wr && is_rme) |=> lba == $past(lba48);
  endproperty
  a_ext_lba: assert property (p_ext_lba) else $error("48-bit address wrong");
  property p_start;
    @(posedge clk) disable iff (rst) (cmd_wr && (is_rm || is_rme)) |=> state == AMR_XFER;
  endproperty
  a_start: assert property (p_start) else $error("read did not start");
  property p_block_irq;
    @(posedge clk) disable iff (rst) (xfer && block_end) |=> intrq;
  endproperty
  a_block_irq: assert property (p_block_irq) else $error("no block interrupt");
  property p_nmax_lba;
    @(posedge clk) disable iff (rst) (cmd_wr && is_nmax && lba_mode) |=> sn_cur == nmax28[7:0];
  endproperty
  a_nmax_lba: assert property (p_nmax_lba) else $error("native max low byte wrong");
  property p_unc_err;
    @(posedge clk) disable iff (rst) unc_hit |=> error[ER_UNC] ##1 status[ST_ERR];
  endproperty
  a_unc_err: assert property (p_unc_err) else $error("error not flagged");
  property p_unc_addr;
    @(posedge clk) disable iff (rst) (unc_hit && ext) |=> {ch_prv, cl_prv, sn_prv, ch_cur, cl_cur, sn_cur} == $past(lba);
  endproperty
  a_unc_addr: assert property (p_unc_addr) else $error("error address wrong");
  // command-level checks on start values, native max layout and completion
  property p_rm_lba;
    @(posedge clk) disable iff (rst) (cmd_wr && is_rm) |=> lba == $past(lba28);
  endproperty
  a_rm_lba: assert property (p_rm_lba) else $error("28-bit address wrong");
  property p_ext_cnt_val;
    @(posedge clk) disable iff (rst) (cmd_wr && is_rme && cnt16 != 16'h0) |=> remain == {1'b0, $past(cnt16)};
  endproperty
  a_ext_cnt_val: assert property (p_ext_cnt_val) else $error("extended count wrong");
  property p_nmax_mid;
    @(posedge clk) disable iff (rst) (cmd_wr && is_nmax && lba_mode) |=> {ch_cur, cl_cur} == nmax28[23:8];
  endproperty
  a_nmax_mid: assert property (p_nmax_mid) else $error("native max middle bytes wrong");
  property p_nmax_head;
    @(posedge clk) disable iff (rst) (cmd_wr && is_nmax && lba_mode) |=> devhd[3:0] == nmax28[27:24];
  endproperty
  a_nmax_head: assert property (p_nmax_head) else $error("native max head bits wrong");
  property p_nmax_chs;
    @(posedge clk) disable iff (rst) (cmd_wr && is_nmax && !lba_mode) |=> {ch_cur, cl_cur, sn_cur} == {MAX_CYL, MAX_SECT};
  endproperty
  a_nmax_chs: assert property (p_nmax_chs) else $error("native max geometry wrong");
  property p_done_idle;
    @(posedge clk) disable iff (rst) (state == AMR_DONE) |=> !status[ST_BSY];
  endproperty
  a_done_idle: assert property (p_done_idle) else $error("busy not cleared");
  property p_abort;
    @(posedge clk) disable iff (rst) (cmd_wr && !(is_rm || is_rme || is_nmax)) |=> error[ER_ABT] ##1 status[ST_ERR];
  endproperty
  a_abort: assert property (p_abort) else $error("unknown command not aborted");
endmodule : amr_top

// ===== tb/amr_media_model.sv
`timescale 1ns/1ps
// media source: words tagged with sector address and word index
module amr_media_model #(
  parameter int SW = 4
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // media port of the drive
  input wire logic        media_req,
  input wire logic [47:0] media_lba,
  input wire logic        media_ready,
  output logic            media_valid,
  output logic [15:0]     media_data,
  output logic            media_unc,
  // test controls
  input wire logic        slow,
  input wire logic        bad_en,
  input wire logic [47:0] bad_lba
);
  logic [7:0]  widx;
  logic [1:0]  ph;
  logic [15:0] last;
  logic        pend;
  // pacing phase, held offer, word index and last word sent
  always_ff @(posedge clk)
  begin
    ph   <= rst ? 2'h0 : ph + 2'h1;
    pend <= !rst && media_valid && !media_ready;
    if (rst || !media_req)
      widx <= 8'h00;
    else if (media_valid && media_ready)
      widx <= (widx == 8'(SW - 1)) ? 8'h00 : widx + 8'h01;
    if (rst)
      last <= 16'h0000;
    else if (media_valid && media_ready)
      last <= media_data;
  end
  // an offer is held until taken; idle data is inverted so stale values never match
  assign media_valid = media_req && (pend || !slow || ph == 2'h0);
  assign media_data  = media_valid ? {media_lba[7:0], widx} : ~last;
  assign media_unc   = media_valid && bad_en && (media_lba == bad_lba);
endmodule : amr_media_model

// ===== tb/tb_ata_multi_read_and_max_query.sv
`timescale 1ns/1ps
module tb_ata_multi_read_and_max_query;
  import amr_pkg::*;
  localparam int SWT = 4;
  logic        clk, rst, tf_wr, tf_rd, tf_hob, data_valid, data_ready, intrq;
  logic        media_req, media_valid, media_unc, media_ready, slow, bad_en, req_d;
  logic [2:0]  tf_addr;
  logic [7:0]  tf_wdata, tf_rdata, blk_size, st, er, dh;
  logic [15:0] data_word, media_data;
  logic [23:0] v, w;
  logic [47:0] media_lba, bad_lba, first_lba;
  logic [15:0] rx_q[$];
  int          n_mismatch, samples_checked, cyc, irqs;

  amr_top #(.SW(SWT), .NATIVE_MAX(48'h0000_1234_5678), .MAX_CYL(16'h2a5c), .MAX_HEAD(4'h9), .MAX_SECT(8'h3e))
    uut (.clk(clk), .rst(rst), .tf_wr(tf_wr), .tf_rd(tf_rd), .tf_addr(tf_addr), .tf_wdata(tf_wdata),
         .tf_hob(tf_hob), .tf_rdata(tf_rdata), .data_valid(data_valid), .data_ready(data_ready),
         .data_word(data_word), .intrq(intrq), .blk_size(blk_size), .media_req(media_req),
         .media_lba(media_lba), .media_valid(media_valid), .media_data(media_data),
         .media_unc(media_unc), .media_ready(media_ready));
  amr_media_model #(.SW(SWT)) media (.clk(clk), .rst(rst), .media_req(media_req), .media_lba(media_lba),
    .media_ready(media_ready), .media_valid(media_valid), .media_data(media_data), .media_unc(media_unc),
    .slow(slow), .bad_en(bad_en), .bad_lba(bad_lba));

  // clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // host sink stalls one cycle in four; monitor collects words and first address
  // at the falling edge, where what the next rising edge takes is settled
  always @(negedge clk)
  begin
    cyc        <= cyc + 1;
    data_ready <= (cyc % 4 != 3);
    if (data_valid && (cyc % 4 != 3))
      rx_q.push_back(data_word);
    if (media_req && !req_d)
      first_lba = media_lba;
    req_d <= media_req;
  end

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic conclude();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude

  // one task-file write, strobe for one cycle
  task automatic tf_write(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk);
    tf_addr  = a;
    tf_wdata = d;
    tf_wr    = 1'b1;
    @(negedge clk);
    tf_wr = 1'b0;
  endtask : tf_write

  // one task-file read; clr pulses the read strobe that clears the interrupt
  task automatic tf_read(input logic [2:0] a, input logic h, input logic clr, output logic [7:0] d);
    @(negedge clk);
    tf_addr = a;
    tf_hob  = h;
    tf_rd   = clr;
    @(negedge clk);
    tf_rd = 1'b0;
    d     = tf_rdata;
  endtask : tf_read

  task automatic ld(input logic [7:0] c, input logic [7:0] s, input logic [7:0] l, input logic [7:0] h);
    tf_write(TF_COUNT, c);
    tf_write(TF_SECNUM, s);
    tf_write(TF_CYLLO, l);
    tf_write(TF_CYLHI, h);
  endtask : ld

  task automatic rd3(input logic h, output logic [23:0] r);
    tf_read(TF_CYLHI, h, 1'b0, r[23:16]);
    tf_read(TF_CYLLO, h, 1'b0, r[15:8]);
    tf_read(TF_SECNUM, h, 1'b0, r[7:0]);
  endtask : rd3

  // issue a command, acknowledge each interrupt by a status read, wait for not busy
  task automatic run_cmd(input logic [7:0] cmd);
    logic seen;
    logic fin;
    irqs = 0;
    fin  = 1'b0;
    rx_q.delete();
    tf_write(TF_CMD, cmd);
    for (int i = 0; i < 20000 && !fin; i++)
    begin
      seen = intrq;
      tf_read(TF_CMD, 1'b0, seen, st);
      if (seen === 1'b1)
        irqs++;
      fin = (st[ST_BSY] === 1'b0 && intrq === 1'b0);
    end
    if (!fin)
    begin
      n_mismatch++;
      $display("Error at %0t: command %h did not finish", $time, cmd);
    end
  endtask : run_cmd

  task automatic chk_words(input logic [7:0] base, input int ns);
    chk(rx_q.size(), ns * SWT);
    foreach (rx_q[k])
      chk(rx_q[k], {base + 8'(k / SWT), 8'(k % SWT)});
  endtask : chk_words

  task automatic t_reset();
    tf_read(TF_CMD, 1'b0, 1'b0, st);
    chk(st, STATUS_IDLE);
    tf_read(TF_ERR, 1'b0, 1'b0, er);
    chk({er, intrq, data_valid, media_req}, 11'h000);
  endtask : t_reset

  // 28-bit block read, three sectors in blocks of two
  task automatic t_mult();
    blk_size = 8'h02;
    ld(8'h03, 8'h40, 8'h12, 8'h34);
    tf_write(TF_DEVHD, 8'he5);
    run_cmd(CMD_READ_MULT);
    chk(first_lba, 48'h0000_0534_1240);
    chk(irqs, 2);
    chk(st, STATUS_IDLE);
    chk_words(8'h40, 3);
  endtask : t_mult

  // 48-bit read of 256 sectors from a slow media, count high byte only
  task automatic t_ext();
    slow     = 1'b1;
    blk_size = 8'h40;
    ld(8'h01, 8'ha1, 8'hb2, 8'hc3);
    ld(8'h00, 8'h10, 8'h20, 8'h30);
    tf_write(TF_DEVHD, 8'h40);
    run_cmd(CMD_READ_MULT_EXT);
    chk(first_lba, 48'hc3b2_a130_2010);
    chk(irqs, 4);
    chk_words(8'h10, 256);
    slow = 1'b0;
  endtask : t_ext

  // zero count runs past 256 sectors until a bad sector aborts it; block size zero: no block interrupts
  task automatic t_unc();
    blk_size = 8'h00;
    bad_lba  = 48'h0102_0304_062c;
    bad_en   = 1'b1;
    ld(8'h00, 8'h03, 8'h02, 8'h01);
    ld(8'h00, 8'h00, 8'h05, 8'h04);
    run_cmd(CMD_READ_MULT_EXT);
    chk({st[ST_BSY], st[ST_ERR]}, 2'b01);
    chk(rx_q.size() > 256 * SWT, 1'b1);
    chk(irqs, 1);
    tf_read(TF_ERR, 1'b0, 1'b0, er);
    chk(er[ER_UNC], 1'b1);
    rd3(1'b0, v);
    rd3(1'b1, w);
    chk({w, v}, bad_lba);
    bad_en = 1'b0;
  endtask : t_unc

  // native maximum in logical then geometry layout
  task automatic t_nmax();
    tf_write(TF_DEVHD, 8'h40);
    run_cmd(CMD_NATIVE_MAX);
    chk(irqs, 1);
    rd3(1'b0, v);
    tf_read(TF_DEVHD, 1'b0, 1'b0, dh);
    chk({dh[3:0], v}, LBA28_MAX);
    tf_write(TF_DEVHD, 8'h00);
    run_cmd(CMD_NATIVE_MAX);
    rd3(1'b0, v);
    tf_read(TF_DEVHD, 1'b0, 1'b0, dh);
    chk({dh[3:0], v}, {4'h9, 16'h2a5c, 8'h3e});
  endtask : t_nmax

  // unknown code is refused with abort
  task automatic t_bad();
    run_cmd(8'hee);
    chk({st[ST_BSY], st[ST_ERR]}, 2'b01);
    tf_read(TF_ERR, 1'b0, 1'b0, er);
    chk({er[ER_ABT], irqs[1:0]}, 3'b101);
  endtask : t_bad

  // main sequence
  initial
  begin
    {tf_wr, tf_rd, tf_hob, slow, bad_en} = '0;
    tf_addr  = 3'h0;
    tf_wdata = 8'h00;
    blk_size = 8'h01;
    bad_lba  = '0;
    rst      = 1'b1;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_mult();
    t_ext();
    t_unc();
    t_nmax();
    t_bad();
    conclude();
  end

  // watchdog
  initial
  begin
    #400000;
    n_mismatch++;
    $display("Error at %0t: run did not finish", $time);
    conclude();
  end
endmodule : tb_ata_multi_read_and_max_query
